// ### hw/alh_axis_limit_home.sv
// Per-axis travel-stop, homing and abort logic with a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Active forward stop blocks forward motion, reverse stop blocks reverse, at once.
// - Stop switch hit while moving gives a ramped stop at the limit ramp-down rate.
// - After a stop switch trip the servo stays on, holding position.
// - Either stop switch trip requests the travel-stop handler in thread zero.
// - Begin toward an active stop switch is refused with error 022; full homing checks the forward stop whatever the home level.
// - Each axis reports forward and reverse switch levels as single bits.
// - Every home input transition toggles the home logic state.
// - Edge seek ramps up to cruise, slews to a home transition, ramps down.
// - Edge seek goes forward when home is high, reverse when low.
// - Index seek slews to index rise, stops, returns to index at crawl velocity.
// - Full homing reverses after first transition and approaches at crawl velocity.
// - Second home change: move forward at crawl until index is seen.
// - After index: stop, return to index, load position with zero.
// - Abort transition stops motion commands immediately with no ramp.
// - Abort switches off servo on axes with drop-on-fault enabled.
// - Abort on other axes stops as fast as possible, servo kept.
// - Abort ends all programs by default; a config bit can change that.
// - Reset input driven low resets the whole controller.
// - Amplifier lockout input disables the amplifier stage in hardware.
// - General inputs 1-8, plus 9-16 in wide configs, are readable individually.
module alh_axis_limit_home (
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  input  wire logic [31:0]                            wb_adr_i,
  input  wire logic [31:0]                            wb_dat_i,
  output logic      [31:0]                            wb_dat_o,
  input  wire logic                                   wb_we_i,
  input  wire logic [3:0]                             wb_sel_i,
  input  wire logic                                   wb_cyc_i,
  input  wire logic                                   wb_stb_i,
  output logic                                        wb_ack_o,
  input  wire alh_pkg::alh_switch_type [alh_pkg::AXES-1:0] switch_i,
  input  wire logic [alh_pkg::AXES-1:0]               motion_done_i,
  input  wire logic                                   abort_i,
  input  wire logic                                   reset_n_i,
  input  wire logic                                   amp_lockout_i,
  input  wire logic [alh_pkg::GP_INPUTS-1:0]          general_input_i,
  output alh_pkg::alh_motion_type [alh_pkg::AXES-1:0] motion_o,
  output logic      [alh_pkg::AXES-1:0]               zero_position_o,
  output logic                                        travel_stop_handler_o,
  output logic                                        terminate_programs_o,
  output logic                                        amp_disable_o,
  output logic                                        controller_reset_o
);

  localparam int unsigned SW_BITS = 4 * alh_pkg::AXES;

  // Synchronisers: stage one feeds stage two only
  logic [SW_BITS-1:0]             sw_meta;
  logic [SW_BITS-1:0]             sw_sync;
  logic [2:0]                     ctl_meta;
  logic [2:0]                     ctl_sync;
  logic [alh_pkg::GP_INPUTS-1:0]  gp_meta;
  logic [alh_pkg::GP_INPUTS-1:0]  gp_sync;

  always_ff @(posedge clk_i) begin
    sw_meta  <= switch_i;
    sw_sync  <= sw_meta;
    ctl_meta <= {abort_i, reset_n_i, amp_lockout_i};
    ctl_sync <= ctl_meta;
    gp_meta  <= general_input_i;
    gp_sync  <= gp_meta;
  end

  alh_pkg::alh_switch_type [alh_pkg::AXES-1:0] sw;
  assign sw = sw_sync;

  logic abort_lvl;
  logic abort_prev;
  logic abort_evt;
  assign abort_lvl = ctl_sync[2];

  // Tracks the pin through reset too, so a pin idling high gives no false abort
  always_ff @(posedge clk_i) begin
    abort_prev <= abort_lvl;
  end
  assign abort_evt = abort_lvl ^ abort_prev;

  // Lockout and controller reset driven straight from synchronised pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_disable_o      <= 1'b0;
      controller_reset_o <= 1'b0;
    end else begin
      amp_disable_o      <= ctl_sync[0];
      controller_reset_o <= ~ctl_sync[1];
    end
  end

  // Registers
  logic [alh_pkg::AXES-1:0]  drop_on_fault;
  logic                      keep_programs;
  logic                      wide_cfg;
  logic [alh_pkg::VEL_W-1:0] ramp_up_rate;
  logic [alh_pkg::VEL_W-1:0] ramp_down_rate;
  logic [alh_pkg::VEL_W-1:0] limit_ramp_down_rate;
  logic [alh_pkg::VEL_W-1:0] cruise_velocity;
  logic [alh_pkg::VEL_W-1:0] return_crawl_velocity;
  logic [alh_pkg::ERR_W-1:0] error_code;
  logic [alh_pkg::AXES-1:0]  home_state;
  logic [alh_pkg::AXES-1:0]  handler_evt;
  logic [alh_pkg::AXES-1:0]  axis_busy;

  logic wb_req;
  logic wb_wr;
  logic [7:0] wb_off;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;
  assign wb_off = wb_adr_i[7:0];

  function automatic logic hit(input logic [7:0] off, input logic [7:0] reg_off);
    hit = (off == reg_off);
  endfunction

  logic                                 cmd_valid;
  logic [alh_pkg::AXIS_SEL_W-1:0]       cmd_axis;
  logic [alh_pkg::OP_W-1:0]             cmd_op;
  logic                                 cmd_dir;
  assign cmd_valid = wb_wr & hit(wb_off, alh_pkg::REG_CMD) & wb_sel_i[0] & wb_sel_i[1];
  assign cmd_axis  = wb_dat_i[alh_pkg::CMD_AXIS_LSB +: alh_pkg::AXIS_SEL_W];
  assign cmd_op    = wb_dat_i[alh_pkg::CMD_OP_LSB +: alh_pkg::OP_W];
  assign cmd_dir   = wb_dat_i[alh_pkg::CMD_DIR_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_on_fault         <= '0;
      keep_programs         <= 1'b0;
      wide_cfg              <= 1'b0;
      ramp_up_rate          <= '0;
      ramp_down_rate        <= '0;
      limit_ramp_down_rate  <= '0;
      cruise_velocity       <= '0;
      return_crawl_velocity <= '0;
    end else if (wb_wr) begin
      if (hit(wb_off, alh_pkg::REG_CFG)) begin
        if (wb_sel_i[0]) drop_on_fault <= wb_dat_i[alh_pkg::CFG_DROP_LSB +: alh_pkg::AXES];
        if (wb_sel_i[1]) keep_programs <= wb_dat_i[alh_pkg::CFG_KEEP_BIT];
        if (wb_sel_i[1]) wide_cfg      <= wb_dat_i[alh_pkg::CFG_WIDE_BIT];
      end else if (hit(wb_off, alh_pkg::REG_RAMP_UP) && wb_sel_i[1:0] == 2'h3) begin
        ramp_up_rate <= wb_dat_i[alh_pkg::VEL_W-1:0];
      end else if (hit(wb_off, alh_pkg::REG_RAMP_DN) && wb_sel_i[1:0] == 2'h3) begin
        ramp_down_rate <= wb_dat_i[alh_pkg::VEL_W-1:0];
      end else if (hit(wb_off, alh_pkg::REG_LIM_DN) && wb_sel_i[1:0] == 2'h3) begin
        limit_ramp_down_rate <= wb_dat_i[alh_pkg::VEL_W-1:0];
      end else if (hit(wb_off, alh_pkg::REG_CRUISE) && wb_sel_i[1:0] == 2'h3) begin
        cruise_velocity <= wb_dat_i[alh_pkg::VEL_W-1:0];
      end else if (hit(wb_off, alh_pkg::REG_CRAWL) && wb_sel_i[1:0] == 2'h3) begin
        return_crawl_velocity <= wb_dat_i[alh_pkg::VEL_W-1:0];
      end
    end
  end

  // Last begin refusal; a new refusal beats a same-cycle clear by write
  logic [alh_pkg::AXES-1:0] refuse;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_code <= alh_pkg::ERR_NONE;
    end else if (|refuse) begin
      error_code <= alh_pkg::ERR_BEGIN_LIM;
    end else if (wb_wr && hit(wb_off, alh_pkg::REG_STATUS) && wb_sel_i[0]) begin
      error_code <= alh_pkg::ERR_NONE;
    end
  end

  // Handler request and program termination, sticky until write-one-to-clear
  logic handler_pend;
  logic term_pend;
  logic evt_clr;
  assign evt_clr = wb_wr & hit(wb_off, alh_pkg::REG_EVENTS) & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      handler_pend <= 1'b0;
      term_pend    <= 1'b0;
    end else begin
      if (|handler_evt) begin
        handler_pend <= 1'b1;
      end else if (evt_clr && wb_dat_i[0]) begin
        handler_pend <= 1'b0;
      end
      if (abort_evt && !keep_programs) begin
        term_pend <= 1'b1;
      end else if (evt_clr && wb_dat_i[1]) begin
        term_pend <= 1'b0;
      end
    end
  end
  assign travel_stop_handler_o = handler_pend;
  assign terminate_programs_o  = term_pend;

  // Per-axis sequencer
  generate
    for (genvar a = 0; a < alh_pkg::AXES; a++) begin : g_axis
      alh_pkg::alh_state_type state;
      alh_pkg::alh_motion_type mot;
      logic home_prev;
      logic idx_prev;
      logic fwd_prev;
      logic rev_prev;
      logic home_edge;
      logic idx_rise;
      logic my_cmd;
      logic homing_mode;
      logic want_fwd;

      assign home_edge = sw[a].home ^ home_prev;
      assign idx_rise  = sw[a].index & ~idx_prev;
      assign my_cmd    = cmd_valid && (cmd_axis == alh_pkg::AXIS_SEL_W'(a));
      assign want_fwd  = (cmd_op == alh_pkg::OP_EDGE) ? sw[a].home :
                         ((cmd_op == alh_pkg::OP_MOVE) ? cmd_dir : 1'b1);
      assign refuse[a] = my_cmd && state == alh_pkg::ALH_IDLE && cmd_op != alh_pkg::OP_STOP &&
                         ((want_fwd && sw[a].fwd_stop) || (!want_fwd && sw[a].rev_stop));
      assign handler_evt[a] = (sw[a].fwd_stop & ~fwd_prev) | (sw[a].rev_stop & ~rev_prev);
      assign axis_busy[a]   = (state != alh_pkg::ALH_IDLE);
      assign motion_o[a]    = mot;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          home_prev     <= 1'b0;
          idx_prev      <= 1'b0;
          fwd_prev      <= 1'b0;
          rev_prev      <= 1'b0;
          home_state[a] <= 1'b0;
        end else begin
          home_prev <= sw[a].home;
          idx_prev  <= sw[a].index;
          fwd_prev  <= sw[a].fwd_stop;
          rev_prev  <= sw[a].rev_stop;
          if (home_edge) begin
            home_state[a] <= ~home_state[a];
          end
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          state              <= alh_pkg::ALH_IDLE;
          mot                <= '0;
          homing_mode        <= 1'b0;
          zero_position_o[a] <= 1'b0;
        end else begin
          zero_position_o[a] <= 1'b0;
          if (abort_evt) begin
            state        <= alh_pkg::ALH_IDLE;
            mot.active   <= 1'b0;
            mot.velocity <= '0;
            mot.ramp     <= alh_pkg::ALH_RAMP_HARD;
            mot.servo_on <= ~drop_on_fault[a];
          end else if (mot.active && ((mot.dir_fwd && sw[a].fwd_stop) ||
                                      (!mot.dir_fwd && sw[a].rev_stop))) begin
            state        <= alh_pkg::ALH_IDLE;
            mot.active   <= 1'b0;
            mot.velocity <= '0;
            mot.ramp     <= alh_pkg::ALH_RAMP_LIMIT;
            mot.rate     <= limit_ramp_down_rate;
            mot.servo_on <= 1'b1;
          end else begin
            case (state)
              alh_pkg::ALH_IDLE: begin
                if (my_cmd && !refuse[a] && cmd_op != alh_pkg::OP_STOP) begin
                  mot.active   <= 1'b1;
                  mot.servo_on <= 1'b1;
                  mot.dir_fwd  <= want_fwd;
                  mot.velocity <= cruise_velocity;
                  mot.ramp     <= alh_pkg::ALH_RAMP_NORMAL;
                  mot.rate     <= ramp_up_rate;
                  homing_mode  <= (cmd_op == alh_pkg::OP_HOME);
                  if (cmd_op == alh_pkg::OP_MOVE) begin
                    state <= alh_pkg::ALH_RUN;
                  end else if (cmd_op == alh_pkg::OP_INDEX) begin
                    state <= alh_pkg::ALH_INDEX;
                  end else if (cmd_op == alh_pkg::OP_EDGE || cmd_op == alh_pkg::OP_HOME) begin
                    mot.dir_fwd <= sw[a].home;
                    state       <= alh_pkg::ALH_SEEK1;
                  end else begin
                    mot.active <= 1'b0;
                  end
                end
              end
              alh_pkg::ALH_RUN, alh_pkg::ALH_SEEK1, alh_pkg::ALH_APPROACH, alh_pkg::ALH_INDEX: begin
                if (my_cmd && cmd_op == alh_pkg::OP_STOP) begin
                  mot.velocity <= '0;
                  mot.rate     <= ramp_down_rate;
                  state        <= alh_pkg::ALH_HALT;
                end else if (state == alh_pkg::ALH_RUN && motion_done_i[a]) begin
                  mot.active <= 1'b0;
                  state      <= alh_pkg::ALH_IDLE;
                end else if (state == alh_pkg::ALH_SEEK1 && home_edge) begin
                  mot.velocity <= '0;
                  mot.rate     <= ramp_down_rate;
                  state        <= homing_mode ? alh_pkg::ALH_STOP1 : alh_pkg::ALH_HALT;
                end else if (state == alh_pkg::ALH_APPROACH && home_edge) begin
                  mot.dir_fwd  <= 1'b1;
                  mot.velocity <= return_crawl_velocity;
                  state        <= alh_pkg::ALH_INDEX;
                end else if (state == alh_pkg::ALH_INDEX && idx_rise) begin
                  mot.velocity <= '0;
                  mot.rate     <= ramp_down_rate;
                  state        <= alh_pkg::ALH_STOP2;
                end
              end
              alh_pkg::ALH_STOP1: begin
                if (motion_done_i[a]) begin
                  mot.dir_fwd  <= ~mot.dir_fwd;
                  mot.velocity <= return_crawl_velocity;
                  state        <= alh_pkg::ALH_APPROACH;
                end
              end
              alh_pkg::ALH_STOP2: begin
                if (motion_done_i[a]) begin
                  mot.dir_fwd  <= ~mot.dir_fwd;
                  mot.velocity <= return_crawl_velocity;
                  state        <= alh_pkg::ALH_RETURN;
                end
              end
              alh_pkg::ALH_RETURN: begin
                // Trajectory side reports arrival at the latched index via done
                if (idx_rise || motion_done_i[a]) begin
                  mot.velocity       <= '0;
                  mot.active         <= 1'b0;
                  zero_position_o[a] <= homing_mode;
                  state              <= alh_pkg::ALH_IDLE;
                end
              end
              alh_pkg::ALH_HALT: begin
                if (motion_done_i[a]) begin
                  mot.active <= 1'b0;
                  state      <= alh_pkg::ALH_IDLE;
                end
              end
              default: begin
                state <= alh_pkg::ALH_IDLE;
              end
            endcase
          end
        end
      end
    end
  endgenerate

  // Read mux and single-cycle ack
  logic [31:0] next_rdata;
  logic [2*alh_pkg::AXES-1:0] lim_levels;
  logic [alh_pkg::POS_W-1:0]  gp_view;

  always_comb begin
    for (int i = 0; i < alh_pkg::AXES; i++) begin
      lim_levels[2*i]   = sw[i].fwd_stop;
      lim_levels[2*i+1] = sw[i].rev_stop;
    end
    gp_view = '0;
    gp_view[alh_pkg::GP_BASE-1:0] = gp_sync[alh_pkg::GP_BASE-1:0];
    if (wide_cfg) begin
      gp_view[alh_pkg::GP_INPUTS-1:alh_pkg::GP_BASE] = gp_sync[alh_pkg::GP_INPUTS-1:alh_pkg::GP_BASE];
    end
    if (hit(wb_off, alh_pkg::REG_CFG)) begin
      next_rdata = {22'h0, wide_cfg, keep_programs, drop_on_fault};
    end else if (hit(wb_off, alh_pkg::REG_RAMP_UP)) begin
      next_rdata = {16'h0, ramp_up_rate};
    end else if (hit(wb_off, alh_pkg::REG_RAMP_DN)) begin
      next_rdata = {16'h0, ramp_down_rate};
    end else if (hit(wb_off, alh_pkg::REG_LIM_DN)) begin
      next_rdata = {16'h0, limit_ramp_down_rate};
    end else if (hit(wb_off, alh_pkg::REG_CRUISE)) begin
      next_rdata = {16'h0, cruise_velocity};
    end else if (hit(wb_off, alh_pkg::REG_CRAWL)) begin
      next_rdata = {16'h0, return_crawl_velocity};
    end else if (hit(wb_off, alh_pkg::REG_STATUS)) begin
      next_rdata = {axis_busy, 16'h0, error_code};
    end else if (hit(wb_off, alh_pkg::REG_SWITCHES)) begin
      next_rdata = {home_state, 8'h0, lim_levels};
    end else if (hit(wb_off, alh_pkg::REG_GPIN)) begin
      next_rdata = gp_view;
    end else if (hit(wb_off, alh_pkg::REG_EVENTS)) begin
      next_rdata = {30'h0, term_pend, handler_pend};
    end else begin
      next_rdata = alh_pkg::WB_UNMAPPED;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ### shared/alh_pkg.sv
// Shared constants and types for the per-axis limit, home and abort logic
package alh_pkg;

  localparam int unsigned AXES       = 8;
  localparam int unsigned GP_INPUTS  = 16;
  localparam int unsigned GP_BASE    = 8;
  localparam int unsigned POS_W      = 32;
  localparam int unsigned VEL_W      = 16;
  localparam int unsigned ERR_W      = 8;
  localparam int unsigned AXIS_SEL_W = 3;
  localparam int unsigned SYNC_W     = 2;

  localparam logic [ERR_W-1:0] ERR_NONE      = 8'h00;
  localparam logic [ERR_W-1:0] ERR_BEGIN_LIM = 8'h16;  // Error code 022 (decimal)

  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_CFG      = 8'h04;
  localparam logic [7:0] REG_RAMP_UP  = 8'h08;
  localparam logic [7:0] REG_RAMP_DN  = 8'h0C;
  localparam logic [7:0] REG_LIM_DN   = 8'h10;
  localparam logic [7:0] REG_CRUISE   = 8'h14;
  localparam logic [7:0] REG_CRAWL    = 8'h18;
  localparam logic [7:0] REG_STATUS   = 8'h1C;
  localparam logic [7:0] REG_SWITCHES = 8'h20;
  localparam logic [7:0] REG_GPIN     = 8'h24;
  localparam logic [7:0] REG_POS      = 8'h28;
  localparam logic [7:0] REG_EVENTS   = 8'h2C;

  // Command register fields
  localparam int unsigned CMD_AXIS_LSB = 0;
  localparam int unsigned CMD_OP_LSB   = 4;
  localparam int unsigned CMD_DIR_BIT  = 8;
  localparam int unsigned OP_W         = 3;

  localparam logic [OP_W-1:0] OP_MOVE  = 3'h1;
  localparam logic [OP_W-1:0] OP_EDGE  = 3'h2;
  localparam logic [OP_W-1:0] OP_INDEX = 3'h3;
  localparam logic [OP_W-1:0] OP_HOME  = 3'h4;
  localparam logic [OP_W-1:0] OP_STOP  = 3'h5;

  // Config register fields
  localparam int unsigned CFG_DROP_LSB  = 0;
  localparam int unsigned CFG_KEEP_BIT  = 8;
  localparam int unsigned CFG_WIDE_BIT  = 9;

  localparam logic [31:0] WB_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    ALH_RAMP_NONE,
    ALH_RAMP_NORMAL,
    ALH_RAMP_LIMIT,
    ALH_RAMP_HARD
  } alh_ramp_type;

  typedef enum {
    ALH_IDLE,
    ALH_RUN,
    ALH_SEEK1,
    ALH_STOP1,
    ALH_APPROACH,
    ALH_INDEX,
    ALH_STOP2,
    ALH_RETURN,
    ALH_HALT
  } alh_state_type;

  // Per-axis command toward the trajectory generator
  typedef struct packed {
    logic              active;
    logic              dir_fwd;
    logic [VEL_W-1:0]  velocity;
    alh_ramp_type      ramp;
    logic [VEL_W-1:0]  rate;
    logic              servo_on;
  } alh_motion_type;

  // Per-axis switch inputs
  typedef struct packed {
    logic fwd_stop;
    logic rev_stop;
    logic home;
    logic index;
  } alh_switch_type;

endpackage

// ### tb/alh_sva.sv
// Port checker for the limit, home and abort block
`timescale 1ns/1ps
`default_nettype none
module alh_sva (
  input wire logic                                    clk_i,
  input wire logic                                    rst_i,
  input wire logic                                    wb_cyc_i,
  input wire logic                                    wb_stb_i,
  input wire logic                                    wb_ack_o,
  input wire logic [31:0]                             wb_dat_o,
  input wire alh_pkg::alh_switch_type [alh_pkg::AXES-1:0] switch_i,
  input wire alh_pkg::alh_motion_type [alh_pkg::AXES-1:0] motion_o,
  input wire logic                                    reset_n_i,
  input wire logic                                    amp_lockout_i,
  input wire logic                                    travel_stop_handler_o,
  input wire logic                                    amp_disable_o,
  input wire logic                                    controller_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pin latency is two sync stages plus the output register
  property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a single pulse after request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
  property p_fwd_block; switch_i[0].fwd_stop [*4] |-> !(motion_o[0].active && motion_o[0].dir_fwd); endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("forward motion with stop active");
  property p_lim_servo; motion_o[0].ramp == alh_pkg::ALH_RAMP_LIMIT |-> motion_o[0].servo_on; endproperty
  a_lim_servo: assert property (p_lim_servo) else $error("servo dropped on limit stop");
  property p_handler; $rose(switch_i[0].rev_stop) |-> ##[3:5] travel_stop_handler_o; endproperty
  a_handler: assert property (p_handler) else $error("handler not requested");
  property p_hard; motion_o[4].ramp == alh_pkg::ALH_RAMP_HARD |-> !motion_o[4].active; endproperty
  a_hard: assert property (p_hard) else $error("hard stop still active");
  property p_lockout; amp_lockout_i [*4] |-> amp_disable_o; endproperty
  a_lockout: assert property (p_lockout) else $error("amplifier not disabled");
  property p_reset_out; !reset_n_i [*4] |-> controller_reset_o; endproperty
  a_reset_out: assert property (p_reset_out) else $error("controller reset missing");
endmodule
bind alh_axis_limit_home alh_sva u_alh_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .switch_i, .motion_o, .reset_n_i, .amp_lockout_i, .travel_stop_handler_o, .amp_disable_o, .controller_reset_o);
`default_nettype wire

// ### tb/alh_switch_model.sv
// Switches, home, encoder index and trajectory-done model
`timescale 1ns/1ps
`default_nettype none
module alh_switch_model #(parameter int HOME_BIT = 3) (
  input  wire alh_pkg::alh_motion_type [7:0] motion_i,
  input  wire logic                          clk_i,
  input  wire logic [7:0]                    fwd_i,
  input  wire logic [7:0]                    rev_i,
  output alh_pkg::alh_switch_type [7:0]      switch_o,
  output logic [7:0]                         done_o
);
  logic [7:0] cnt [8];
  initial begin
    switch_o = '0;
    foreach (cnt[i]) cnt[i] = 8'h0;
  end
  // Done follows the command at once, so a fresh start at nonzero velocity never looks finished
  always_comb begin
    for (int i = 0; i < 8; i++) done_o[i] = !motion_i[i].active || motion_i[i].velocity == 16'h0;
  end
  // Home and index only move while the axis travels; larger HOME_BIT answers slower
  always @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (motion_i[i].active) cnt[i] <= cnt[i] + 8'h1;
      switch_o[i] <= '{fwd_i[i], rev_i[i], cnt[i][HOME_BIT], motion_i[i].active && cnt[i][2:0] == 3'h7};
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the limit, home and abort block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, abort_i, reset_n_i, amp_lockout_i;
  logic travel_stop_handler_o, terminate_programs_o, amp_disable_o, controller_reset_o;
  logic [31:0]                    wb_adr_i, wb_dat_i, wb_dat_o, lf, e;
  logic [3:0]                     wb_sel_i;
  logic [7:0]                     fwd, rev, done, zero_position_o;
  logic [15:0]                    general_input_i;
  alh_pkg::alh_switch_type [7:0]  switch_i;
  alh_pkg::alh_motion_type [7:0]  motion_o;
  logic [31:0]                    q[$];
  int                             err_total, n_compared, cycles;
  alh_axis_limit_home u_alh_axis_limit_home (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .switch_i, .motion_done_i(done), .abort_i, .reset_n_i,
    .amp_lockout_i, .general_input_i, .motion_o, .zero_position_o, .travel_stop_handler_o,
    .terminate_programs_o, .amp_disable_o, .controller_reset_o);
  alh_switch_model #(.HOME_BIT(3)) u_alh_switch_model (.motion_i(motion_o), .clk_i, .fwd_i(fwd),
    .rev_i(rev), .switch_o(switch_i), .done_o(done));
  always #20 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until ack is sampled; only the timeout ends a hang
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, 24'h0, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    wb(1'h0, a, 32'h0);
  endtask
  task automatic idle_wait(input int a);
    for (int k = 0; k < 50 && motion_o[a].active !== 1'h0; k++) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) chk(wb_dat_o, q.pop_front());
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, abort_i, amp_lockout_i, fwd, rev, err_total, n_compared, cycles} = '0;
    {rst_i, reset_n_i, wb_sel_i, wb_adr_i, wb_dat_i, general_input_i} = {2'h3, 4'hF, 64'h0, 16'h0};
    lf = lfsr(32'h0001_2503);
    repeat (20) @(posedge clk_i);
    {rst_i, general_input_i, fwd, rev} <= {1'h0, lf[15:0], lf[23:16], lf[31:24]};
    repeat (4) @(posedge clk_i);
    e = 32'h0;
    for (int i = 0; i < 8; i++) {e[2*i+1], e[2*i]} = {lf[24+i], lf[16+i]};
    rd(alh_pkg::REG_SWITCHES, e);
    rd(alh_pkg::REG_GPIN, {24'h0, lf[7:0]});
    wb(1'h1, alh_pkg::REG_CFG, 32'h0000_0210);
    rd(alh_pkg::REG_GPIN, {16'h0, lf[15:0]});
    rd(alh_pkg::REG_POS, alh_pkg::WB_UNMAPPED);
    {fwd, rev} <= 16'h0100;
    lf = lfsr(lf);
    wb(1'h1, alh_pkg::REG_LIM_DN, lf);
    wb(1'h1, alh_pkg::REG_CRUISE, 32'h0000_0100);
    wb(1'h1, alh_pkg::REG_CRAWL, 32'h0000_0010);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0110);
    rd(alh_pkg::REG_STATUS, {24'h0, alh_pkg::ERR_BEGIN_LIM});
    wb(1'h1, alh_pkg::REG_STATUS, 32'h0);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0010);
    rd(alh_pkg::REG_STATUS, 32'h0100_0000);
    wb(1'h1, alh_pkg::REG_EVENTS, 32'h3);
    rev <= 8'h01;
    idle_wait(0);
    chk({motion_o[0].ramp, motion_o[0].rate, motion_o[0].servo_on}, {alh_pkg::ALH_RAMP_LIMIT, lf[15:0], 1'h1});
    chk({travel_stop_handler_o, terminate_programs_o}, 2'h2);
    rd(alh_pkg::REG_EVENTS, 32'h1);
    wb(1'h1, alh_pkg::REG_EVENTS, 32'h3);
    rd(alh_pkg::REG_EVENTS, 32'h0);
    {fwd, rev} <= 16'h0;
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0023);
    repeat (3) @(posedge clk_i);
    chk({motion_o[3].active, motion_o[3].dir_fwd}, 2'h2);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0036);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0056);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0042);
    for (int k = 0; k < 400 && zero_position_o[2] !== 1'h1; k++) @(posedge clk_i);
    chk(zero_position_o[2], 1'h1);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0144);
    wb(1'h1, alh_pkg::REG_CMD, 32'h0000_0145);
    abort_i <= 1'h1;
    idle_wait(5);
    chk({motion_o[4].ramp, motion_o[4].servo_on, motion_o[5].ramp, motion_o[5].servo_on},
        {alh_pkg::ALH_RAMP_HARD, 1'h0, alh_pkg::ALH_RAMP_HARD, 1'h1});
    chk({travel_stop_handler_o, terminate_programs_o}, 2'h1);
    rd(alh_pkg::REG_EVENTS, 32'h2);
    {amp_lockout_i, reset_n_i} <= 2'h2;
    repeat (5) @(posedge clk_i);
    chk({amp_disable_o, controller_reset_o}, 2'h3);
    {amp_lockout_i, reset_n_i} <= 2'h1;
    repeat (5) @(posedge clk_i);
    chk({amp_disable_o, controller_reset_o}, 2'h0);
    chk(q.size(), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
